// *** rtl/adsc_top.sv ***
// Control and status byte interface of the analog companion die.
// Assumes an SPI master on spi_*, analog monitors as levels on analog_in.
//
// What this block does
// RL1 - Stop and Sleep disable the bus transmitter; Stop keeps the receiver on.
// RL2 - Pull-up bit set disconnects bus pull-up during Sleep or Stop.
// RL3 - In Stop, long dominant then rising edge wakes and sets bus wake flag.
// RL4 - Control byte: slew select, pull-up, three high-side enables, mode select.
// RL5 - Status byte: source, bus flag, high, low, regulator, high-side, wake inputs.
// RL6 - Slew and enables clear on either reset; pull-up bit only on power-on.
// RL7 - Slew codes: normal, slow, fast download, low-power request.
// RL8 - High-side enable bit one switches output on; reset clears all.
// RL9 - Mode codes: Sleep, Stop, watchdog clear, Run.
// RL10 - Sleep entered only after two identical Sleep command bytes.
// RL11 - Stop entered only after two identical Stop command bytes.
// RL12 - Source bit one means the lower bits report the wake source.
// RL13 - First read after reset shows battery fail in bit four.
// RL14 - Bus fault sets bus flag, blocks transmitter until gone and cleared.
// RL15 - Reading the bus flag as set clears it.
// RL16 - Supply over-voltage shows in bit five.
// RL17 - Supply under-voltage shows in bit four.
// RL18 - Regulator over-temperature prewarning shows in bit three.
// RL19 - Any high-side over-temperature turns all off and sets bit two.
// RL20 - High sides return only after flag read-clear then a separate write.
// RL21 - Bits one and zero follow wake inputs, or name the waking input.
// RL22 - Stop left by wake interrupt; Sleep left by reset, regulator on.
// RL23 - Transmitter enabled only in Normal mode.
// RL24 - Sleep and Stop keep high-side outputs off.
// RL25 - Each transfer is one full-duplex byte: control in, status out.
// RL26 - A low-power byte that is not the second of a pair stays Normal.
`timescale 1ns/10ps
`include "adsc_consts.svh"

module adsc_top
#(
   parameter int WAKE_FILTER_CYC = `ADSC_WAKE_FILTER_NS * `ADSC_CLK_MHZ / 1000
)
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic spi_sclk,
   input wire logic spi_ss_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   input wire logic bus_rx,
   input wire logic wake_input_a,
   input wire logic wake_input_b,
   input wire logic sys_reset_n,
   input wire adsc_pkg::adsc_analog_t analog_in,
   output adsc_pkg::adsc_drive_t drive_out,
   output logic wake_irq,
   output logic watchdog_clear
);
   import adsc_pkg::*;

   localparam int SYNC_W = 12;
   localparam logic [15:0] WAKE_CNT = 16'(WAKE_FILTER_CYC);

   // Link side, clocked by the master's serial clock
   logic link_clr;
   logic [2:0] bit_cnt;
   logic [2:0] next_bit_cnt;
   logic [6:0] rx_shift;
   logic [6:0] next_rx_shift;
   logic miso_q;
   logic next_miso_q;
   logic [7:0] rx_byte;
   logic [7:0] next_rx_byte;
   logic rx_toggle;
   logic next_rx_toggle;

   // Status word offered to the link, held for the whole frame
   logic [7:0] tx_word;
   logic [7:0] next_tx_word;

   assign link_clr = ~rstn | spi_ss_n;

   always_comb
   begin
      next_bit_cnt = bit_cnt + 3'h1;
      next_rx_shift = {rx_shift[5:0], spi_mosi};
      next_miso_q = tx_word[3'h7 - bit_cnt]; // [RL25]
   end

   always_ff @(posedge spi_sclk or posedge link_clr)
   begin
      if (link_clr)
      begin
         bit_cnt <= 3'h0;
         rx_shift <= 7'h00;
         miso_q <= 1'b0;
      end
      else
      begin
         bit_cnt <= next_bit_cnt;
         rx_shift <= next_rx_shift;
         miso_q <= next_miso_q;
      end
   end

   always_comb
   begin
      next_rx_byte = rx_byte;
      next_rx_toggle = rx_toggle;
      if (!spi_ss_n && bit_cnt == 3'h7)
      begin
         next_rx_byte = {rx_shift, spi_mosi}; // [RL25]
         next_rx_toggle = ~rx_toggle;
      end
   end

   always_ff @(posedge spi_sclk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_byte <= 8'h00;
         rx_toggle <= 1'b0;
      end
      else
      begin
         rx_byte <= next_rx_byte;
         rx_toggle <= next_rx_toggle;
      end
   end

   assign spi_miso = miso_q;

   // Two-stage synchronisers for everything arriving from outside the clock except rx_byte, which is read directly
   logic [SYNC_W-1:0] sync_in;
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   logic [SYNC_W-1:0] sync_last;

   assign sync_in = {rx_toggle, spi_ss_n, sys_reset_n, bus_rx, wake_input_b, wake_input_a, analog_in};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++)
      begin : g_sync
         always_ff @(posedge clock or negedge rstn)
         begin
            if (!rstn)
            begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
               sync_last[gi] <= 1'b0;
            end
            else
            begin
               sync_a[gi] <= sync_in[gi];
               sync_b[gi] <= sync_a[gi];
               sync_last[gi] <= sync_b[gi];
            end
         end
      end
   endgenerate

   adsc_analog_t ana;
   logic tog_s;
   logic ss_s;
   logic rst_s;
   logic rx_s;
   logic wb_s;
   logic wa_s;
   logic frame_start;
   logic byte_done;
   logic rx_rise;
   logic wa_edge;
   logic wb_edge;

   assign ana = sync_b[5:0];
   assign wa_s = sync_b[6];
   assign wb_s = sync_b[7];
   assign rx_s = sync_b[8];
   assign rst_s = sync_b[9];
   assign ss_s = sync_b[10];
   assign tog_s = sync_b[11];
   assign frame_start = sync_last[10] & ~ss_s;
   assign byte_done = sync_last[11] ^ tog_s;
   assign rx_rise = rx_s & ~sync_last[8];
   assign wa_edge = wa_s ^ sync_last[6];
   assign wb_edge = wb_s ^ sync_last[7];

   // Device state
   adsc_mode_t mode;
   adsc_mode_t next_mode;
   logic [1:0] slew;
   logic [1:0] next_slew;
   logic pullup_bit;
   logic next_pullup_bit;
   logic [2:0] hs_en;
   logic [2:0] next_hs_en;
   logic [7:0] prev_cmd;
   logic [7:0] next_prev_cmd;
   logic prev_ok;
   logic next_prev_ok;
   logic bus_flag;
   logic next_bus_flag;
   logic tx_block;
   logic next_tx_block;
   logic high_side_overtemp_flag;
   logic next_high_side_overtemp_flag;
   logic interrupt_source_indicator;
   logic next_interrupt_source_indicator;
   logic [1:0] wake_src;
   logic [1:0] next_wake_src;
   logic first_read;
   logic next_first_read;
   logic bat_flag;
   logic next_bat_flag;
   logic [15:0] dom_cnt;
   logic [15:0] next_dom_cnt;
   adsc_drive_t next_drive;
   logic next_wake_irq;
   logic next_watchdog_clear;

   logic [7:0] cmd;
   logic [7:0] status;
   logic lp_cmd;
   logic lin_wake;
   logic pin_wake;
   logic hs_block;

   always_comb
   begin
      cmd = rx_byte;
      lp_cmd = cmd[`ADSC_CTL_SLEW_HI:`ADSC_CTL_SLEW_LO] == `ADSC_SLEW_LOWPOWER
         && cmd[`ADSC_CTL_HS_HI:`ADSC_CTL_HS_LO] == 3'h0
         && !cmd[`ADSC_CTL_MODE_HI]; // [RL10] [RL11]
      lin_wake = mode == mode_stop && rx_rise && dom_cnt >= WAKE_CNT; // [RL3]
      pin_wake = mode == mode_stop && (wa_edge || wb_edge);
      hs_block = high_side_overtemp_flag | ana.high_side_overtemp;

      next_mode = mode;
      next_slew = slew;
      next_pullup_bit = pullup_bit;
      next_hs_en = hs_en;
      next_prev_cmd = prev_cmd;
      next_prev_ok = prev_ok;
      next_wake_src = wake_src;
      next_first_read = first_read;
      next_wake_irq = 1'b0;
      next_watchdog_clear = 1'b0;
      next_tx_word = tx_word;

      // Dominant length in Stop, saturating
      next_dom_cnt = 16'h0000;
      if (mode == mode_stop && !rx_s)
      begin
         next_dom_cnt = (dom_cnt == 16'hffff) ? dom_cnt : dom_cnt + 16'h0001; // [RL3]
      end

      // Sticky flags; a set in the clearing cycle wins
      next_bus_flag = lin_wake | ana.bus_fault
         | (bus_flag & ~(byte_done & tx_word[6])); // [RL3] [RL14] [RL15]
      next_tx_block = ana.bus_fault | (tx_block & bus_flag); // [RL14]
      next_high_side_overtemp_flag = ana.high_side_overtemp | (high_side_overtemp_flag & ~(byte_done & tx_word[2])); // [RL19] [RL20]
      next_interrupt_source_indicator = lin_wake | pin_wake | (interrupt_source_indicator & ~(byte_done & tx_word[7])); // [RL12]
      next_bat_flag = ana.battery_fail | (bat_flag & first_read); // [RL13]

      if (byte_done)
      begin
         next_first_read = 1'b0;
      end

      case (mode)
         mode_normal:
         begin
            if (byte_done)
            begin
               next_pullup_bit = cmd[`ADSC_CTL_PULLUP]; // [RL4] [RL2]
               if (cmd[`ADSC_CTL_SLEW_HI:`ADSC_CTL_SLEW_LO] != `ADSC_SLEW_LOWPOWER)
               begin
                  next_slew = cmd[`ADSC_CTL_SLEW_HI:`ADSC_CTL_SLEW_LO]; // [RL7]
               end
               next_hs_en = hs_block ? 3'h0 : cmd[`ADSC_CTL_HS_HI:`ADSC_CTL_HS_LO]; // [RL8] [RL20]
               next_watchdog_clear = cmd[`ADSC_CTL_MODE_HI:`ADSC_CTL_MODE_LO] == `ADSC_MODE_WDCLEAR; // [RL9]
               if (lp_cmd && prev_ok && prev_cmd == cmd)
               begin
                  next_mode = (cmd[`ADSC_CTL_MODE_HI:`ADSC_CTL_MODE_LO] == `ADSC_MODE_STOP)
                     ? mode_stop : mode_sleep; // [RL9] [RL10] [RL11]
                  next_prev_ok = 1'b0;
               end
               else
               begin
                  next_prev_cmd = cmd; // [RL26]
                  next_prev_ok = lp_cmd;
               end
            end
         end
         mode_stop:
         begin
            if (lin_wake || pin_wake)
            begin
               next_mode = mode_normal; // [RL22]
               next_wake_irq = 1'b1;
               next_wake_src = {wb_edge, wa_edge}; // [RL21]
            end
         end
         mode_sleep:
         begin
            next_mode = mode_sleep;
         end
         default:
         begin
            next_mode = mode_normal;
         end
      endcase

      if (ana.high_side_overtemp)
      begin
         next_hs_en = 3'h0; // [RL19]
      end

      // Device reset: Sleep exits here, pull-up bit survives
      if (!rst_s)
      begin
         next_mode = mode_normal; // [RL22]
         next_slew = `ADSC_SLEW_RST; // [RL6]
         next_hs_en = `ADSC_HS_RST; // [RL6] [RL8]
         next_prev_ok = 1'b0;
         next_first_read = 1'b1;
      end

      // Status byte snapshot for the coming frame
      status[7] = interrupt_source_indicator; // [RL5] [RL12]
      status[6] = bus_flag;
      status[5] = ana.supply_high; // [RL16]
      status[4] = first_read ? bat_flag : ana.supply_low; // [RL13] [RL17]
      status[3] = ana.regulator_overtemp; // [RL18]
      status[2] = high_side_overtemp_flag;
      status[1:0] = interrupt_source_indicator ? wake_src : {wb_s, wa_s}; // [RL21]
      if (frame_start)
      begin
         next_tx_word = status; // [RL25]
      end

      next_drive.tx_enable = next_mode == mode_normal && !next_tx_block; // [RL1] [RL23] [RL14]
      next_drive.rx_enable = next_mode != mode_sleep; // [RL1]
      next_drive.bus_pullup_disconnect = next_pullup_bit && next_mode != mode_normal; // [RL2]
      next_drive.regulator_on = next_mode != mode_sleep; // [RL22]
      next_drive.slew_lowpower_select = next_slew; // [RL7]
      next_drive.high_side_on = (next_mode == mode_normal && !next_high_side_overtemp_flag)
         ? next_hs_en : 3'h0; // [RL24] [RL19]
      next_drive.stop_mode = next_mode == mode_stop;
      next_drive.sleep_mode = next_mode == mode_sleep;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         mode <= mode_normal;
         slew <= `ADSC_SLEW_RST; // [RL6]
         pullup_bit <= `ADSC_PULLUP_RST; // [RL6]
         hs_en <= `ADSC_HS_RST;
         prev_cmd <= 8'h00;
         prev_ok <= 1'b0;
         bus_flag <= 1'b0;
         tx_block <= 1'b0;
         high_side_overtemp_flag <= 1'b0;
         interrupt_source_indicator <= 1'b0;
         wake_src <= 2'h0;
         first_read <= 1'b1;
         bat_flag <= 1'b0;
         dom_cnt <= 16'h0000;
         tx_word <= 8'h00;
         drive_out <= adsc_drive_rst;
         wake_irq <= 1'b0;
         watchdog_clear <= 1'b0;
      end
      else
      begin
         mode <= next_mode;
         slew <= next_slew;
         pullup_bit <= next_pullup_bit;
         hs_en <= next_hs_en;
         prev_cmd <= next_prev_cmd;
         prev_ok <= next_prev_ok;
         bus_flag <= next_bus_flag;
         tx_block <= next_tx_block;
         high_side_overtemp_flag <= next_high_side_overtemp_flag;
         interrupt_source_indicator <= next_interrupt_source_indicator;
         wake_src <= next_wake_src;
         first_read <= next_first_read;
         bat_flag <= next_bat_flag;
         dom_cnt <= next_dom_cnt;
         tx_word <= next_tx_word;
         drive_out <= next_drive;
         wake_irq <= next_wake_irq;
         watchdog_clear <= next_watchdog_clear;
      end
   end
endmodule

// *** rtl/adsc_consts.svh ***
// Constants for the analog die control and status byte interface.
// Assumes inclusion by bare name from the top module.
`ifndef ADSC_CONSTS_SVH
`define ADSC_CONSTS_SVH

// Control byte field positions
`define ADSC_CTL_SLEW_HI 7
`define ADSC_CTL_SLEW_LO 6
`define ADSC_CTL_PULLUP 5
`define ADSC_CTL_HS_HI 4
`define ADSC_CTL_HS_LO 2
`define ADSC_CTL_MODE_HI 1
`define ADSC_CTL_MODE_LO 0

// Slew and low-power select codes
`define ADSC_SLEW_NORMAL 2'h0
`define ADSC_SLEW_SLOW 2'h1
`define ADSC_SLEW_FAST 2'h2
`define ADSC_SLEW_LOWPOWER 2'h3

// Mode select codes
`define ADSC_MODE_SLEEP 2'h0
`define ADSC_MODE_STOP 2'h1
`define ADSC_MODE_WDCLEAR 2'h2
`define ADSC_MODE_RUN 2'h3

// Reset values
`define ADSC_SLEW_RST 2'h0
`define ADSC_HS_RST 3'h0
`define ADSC_PULLUP_RST 1'b0

// Timing
`define ADSC_CLK_MHZ 250
`define ADSC_WAKE_FILTER_NS 30000

`endif

// *** rtl/adsc_pkg.sv ***
// Types for the analog die control and status byte interface.
// Assumes the constants header sits beside it.
package adsc_pkg;
   typedef enum logic [2:0]
   {
      mode_normal = 3'b001,
      mode_stop = 3'b010,
      mode_sleep = 3'b100
   } adsc_mode_t;

   typedef struct packed {
      logic bus_fault;
      logic supply_high;
      logic supply_low;
      logic battery_fail;
      logic regulator_overtemp;
      logic high_side_overtemp;
   } adsc_analog_t;

   typedef struct packed {
      logic tx_enable;
      logic rx_enable;
      logic bus_pullup_disconnect;
      logic regulator_on;
      logic [1:0] slew_lowpower_select;
      logic [2:0] high_side_on;
      logic stop_mode;
      logic sleep_mode;
   } adsc_drive_t;

   localparam adsc_drive_t adsc_drive_rst = '{
      tx_enable: 1'b1,
      rx_enable: 1'b1,
      bus_pullup_disconnect: 1'b0,
      regulator_on: 1'b1,
      slew_lowpower_select: 2'h0,
      high_side_on: 3'h0,
      stop_mode: 1'b0,
      sleep_mode: 1'b0
   };
endpackage

// *** verification/adsc_top_props.sv ***
// Assertions on the ports of the analog die control and status block.
// Assumes it is bound onto adsc_top by the bench.
`timescale 1ns/10ps
module adsc_top_props
import adsc_pkg::*;
#(
   parameter int WAKE_FILTER_CYC = 20
)
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic spi_ss_n,
   input wire logic spi_miso,
   input wire adsc_pkg::adsc_analog_t analog_in,
   input wire adsc_pkg::adsc_drive_t drive_out,
   input wire logic wake_irq,
   input wire logic watchdog_clear
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   AST_STOP_LINK: assert property (drive_out.stop_mode |-> !drive_out.tx_enable && drive_out.rx_enable)
      else $error("stop mode with transmitter on or receiver off");
   AST_TX_NORMAL: assert property (drive_out.tx_enable |-> !drive_out.stop_mode && !drive_out.sleep_mode)
      else $error("transmitter on outside normal mode");
   AST_LP_HS_OFF: assert property ((drive_out.stop_mode || drive_out.sleep_mode) |-> drive_out.high_side_on == 3'h0)
      else $error("high side on in low power");
   AST_SLEW_CODE: assert property (drive_out.slew_lowpower_select != 2'h3)
      else $error("low power code reached slew output");
   AST_HS_TRIP: assert property ($rose(analog_in.high_side_overtemp) |-> ##[1:6] drive_out.high_side_on == 3'h0)
      else $error("high sides not off after over-temperature");
   AST_FAULT_TX: assert property ($rose(analog_in.bus_fault) |-> ##[1:6] !drive_out.tx_enable)
      else $error("transmitter not off after bus fault");
   AST_WAKE_EXIT: assert property (wake_irq |-> ##[0:1] !drive_out.stop_mode)
      else $error("still in stop after wake");
   AST_IRQ_PULSE: assert property (wake_irq |=> !wake_irq)
      else $error("wake pulse longer than one cycle");
   AST_WDOG: assert property (watchdog_clear |-> (!drive_out.stop_mode && !drive_out.sleep_mode) ##1 !watchdog_clear)
      else $error("bad watchdog clear pulse");
   AST_MISO_IDLE: assert property (spi_ss_n && $past(spi_ss_n) |-> !spi_miso)
      else $error("serial out active outside frame");
   cover property (drive_out.stop_mode);
   cover property (drive_out.sleep_mode);
   cover property (watchdog_clear);
endmodule

// *** verification/adsc_spi_master.sv ***
// SPI master model standing in for the embedded controller.
// Assumes idle-low serial clock, MSB first, status taken on the falling edge.
`timescale 1ns/10ps
module adsc_spi_master
(
   output logic spi_sclk,
   output logic spi_ss_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   initial
   begin
      spi_sclk = 1'b0;
      spi_ss_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // One full-duplex byte per frame; clock stands still between frames
   task automatic xfer(input logic [7:0] ctl, output logic [7:0] sts);
      #1.3;
      spi_ss_n = 1'b0;
      #42;
      for (int k = 7; k >= 0; k--)
      begin
         spi_mosi = ctl[k];
         #1;
         spi_sclk = 1'b1;
         #40;
         spi_sclk = 1'b0;
         sts[k] = spi_miso;
         #39;
      end
      spi_ss_n = 1'b1;
      spi_mosi = ~spi_mosi;
      #60;
   endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the analog die control and status block.
// Assumes the SPI master model and the bound checker beside it.
`timescale 1ns/10ps
module tb_top;
   import adsc_pkg::*;
   localparam int WFC = 20;
   logic clock, rstn, bus_rx, wake_input_a, wake_input_b, sys_reset_n;
   logic spi_sclk, spi_ss_n, spi_mosi, spi_miso, wake_irq, watchdog_clear;
   adsc_analog_t analog_in;
   adsc_drive_t drive_out;
   int num_errors, cmp_count, wd_count, m_slew, m_hs, m_hsok, i;
   logic [31:0] rnd;
   logic [7:0] st;

   adsc_top #(.WAKE_FILTER_CYC(WFC)) uut (.clock(clock), .rstn(rstn), .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .bus_rx(bus_rx), .wake_input_a(wake_input_a),
      .wake_input_b(wake_input_b), .sys_reset_n(sys_reset_n), .analog_in(analog_in), .drive_out(drive_out),
      .wake_irq(wake_irq), .watchdog_clear(watchdog_clear));
   adsc_spi_master master (.spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

   always #2 clock = ~clock;
   always @(posedge clock) if (watchdog_clear === 1'b1) wd_count <= wd_count + 1;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      if (num_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   // One byte out, status in; model follows the written fields
   task automatic wr(input logic [7:0] ctl);
      master.xfer(ctl, st);
      cyc(12);
      if (ctl[7:6] != 2'h3) m_slew = int'(ctl[7:6]);
      m_hs = m_hsok ? int'(ctl[4:2]) : 0;
   endtask

   task automatic chk_drv();
      check("slew", {6'h0, drive_out.slew_lowpower_select}, m_slew[7:0]);
      check("high_side", {5'h0, drive_out.high_side_on}, m_hs[7:0]);
   endtask

   task automatic chk_mode(input logic [7:0] exp);
      check("mode", {6'h0, drive_out.stop_mode, drive_out.sleep_mode}, exp);
   endtask

   initial
   begin
      clock = 1'b0;
      rstn = 1'b0;
      bus_rx = 1'b1;
      wake_input_a = 1'b0;
      wake_input_b = 1'b0;
      sys_reset_n = 1'b1;
      analog_in = '0;
      num_errors = 0;
      cmp_count = 0;
      wd_count = 0;
      m_hsok = 1;
      rnd = 32'hc8ba3238;
      cyc(20);
      rstn <= 1'b1;
      cyc(10);
      check("drive_hi", drive_out[10:3], 8'hd0);
      check("drive_lo", {5'h0, drive_out[2:0]}, 8'h00);
      analog_in.battery_fail <= 1'b1;
      cyc(10);
      wr(8'h03);
      check("first_d4", st & 8'h10, 8'h10);
      wr(8'h03);
      check("low_d4", st & 8'h10, 8'h00);
      for (i = 0; i < 3; i++)
      begin
         rnd = xs(rnd);
         wr({i[1:0], 1'b0, rnd[2:0], 2'h3});
         chk_drv();
      end
      wr(8'hdf);
      check("slew_keep", {6'h0, drive_out.slew_lowpower_select}, 8'h02);
      check("wdog_idle", wd_count[7:0], 8'h00);
      wr(8'h02);
      check("wdog", wd_count[7:0], 8'h01);
      for (i = 0; i < 4; i++)
      begin
         rnd = xs(rnd);
         analog_in.supply_high <= rnd[0];
         analog_in.supply_low <= rnd[1];
         analog_in.regulator_overtemp <= rnd[2];
         wake_input_a <= rnd[3];
         wake_input_b <= rnd[4];
         cyc(10);
         wr(8'h03);
         check("live", st & 8'h3b, {2'h0, rnd[0], rnd[1], rnd[2], 1'b0, rnd[4:3]});
      end
      // Only the bus fault monitor raised
      analog_in <= adsc_analog_t'(6'h20);
      wake_input_a <= 1'b0;
      wake_input_b <= 1'b0;
      cyc(10);
      check("tx_fault", {7'h0, drive_out.tx_enable}, 8'h00);
      analog_in.bus_fault <= 1'b0;
      cyc(10);
      check("tx_held", {7'h0, drive_out.tx_enable}, 8'h00);
      wr(8'h03);
      check("d6_set", st & 8'h40, 8'h40);
      wr(8'h03);
      check("d6_clr", st & 8'h40, 8'h00);
      check("tx_back", {7'h0, drive_out.tx_enable}, 8'h01);
      wr(8'h1f);
      chk_drv();
      analog_in.high_side_overtemp <= 1'b1;
      cyc(10);
      check("hs_trip", {5'h0, drive_out.high_side_on}, 8'h00);
      analog_in.high_side_overtemp <= 1'b0;
      m_hsok = 0;
      wr(8'h1f);
      check("d2", st & 8'h04, 8'h04);
      chk_drv();
      m_hsok = 1;
      wr(8'h17);
      chk_drv();
      wr(8'hc1);
      wr(8'hc0);
      chk_mode(8'h00);
      wr(8'h43);
      wr(8'he1);
      chk_mode(8'h00);
      wr(8'he1);
      check("stop_hi", drive_out[10:3], 8'h74);
      check("stop_lo", {5'h0, drive_out[2:0]}, 8'h02);
      bus_rx <= 1'b0;
      cyc(WFC + 8);
      bus_rx <= 1'b1;
      for (i = 0; i < 60 && wake_irq !== 1'b1; i++) @(negedge clock);
      check("wake_irq", {7'h0, wake_irq}, 8'h01);
      if (num_errors > 0) wrap_up();
      cyc(5);
      chk_mode(8'h00);
      wr(8'h43);
      check("wake_src", st & 8'hc0, 8'hc0);
      wr(8'he1);
      wr(8'he1);
      wake_input_a <= 1'b1;
      cyc(10);
      chk_mode(8'h00);
      wr(8'h03);
      check("pin_src", st & 8'hc3, 8'h81);
      wr(8'hc0);
      chk_mode(8'h00);
      wr(8'hc0);
      check("sleep", {4'h0, drive_out[10], drive_out[8:7], drive_out[0]}, 8'h01);
      sys_reset_n <= 1'b0;
      cyc(5);
      sys_reset_n <= 1'b1;
      cyc(10);
      check("sys_rst", drive_out[10:3], 8'hd0);
      wrap_up();
   end

   initial
   begin
      #300000;
      check("timeout", 8'h00, 8'h01);
      wrap_up();
   end
endmodule

bind adsc_top adsc_top_props #(.WAKE_FILTER_CYC(WAKE_FILTER_CYC)) props (.clock(clock), .rstn(rstn),
   .spi_ss_n(spi_ss_n), .spi_miso(spi_miso), .analog_in(analog_in), .drive_out(drive_out),
   .wake_irq(wake_irq), .watchdog_clear(watchdog_clear));
